// ---- hdl/tsm_translation.v ----
// translation shadow arrays, unified array and management instruction engine
`timescale 1ns/1ns
`default_nettype none
`include "tsm_translation_map.vh"

// small fully associative shadow array with round-robin refill
module tsm_shadow #(
   parameter N = 4,
   parameter IW = 2
) (
   input wire clk,
   input wire rst_n,
   input wire flush,
   input wire [21:0] lookupEpn,
   input wire lookupTs,
   input wire [7:0] address_space_process_tag,
   input wire fillEn,
   input wire [21:0] fillEpn,
   input wire fillTs,
   input wire [7:0] fillTid,
   input wire [25:0] fillData,
   output reg hit,
   output reg [25:0] hitData
);
   reg [N-1:0] valid_reg;
   reg [21:0] epn_reg [0:N-1];
   reg ts_reg [0:N-1];
   reg [7:0] tid_reg [0:N-1];
   reg [25:0] data_reg [0:N-1];
   reg [IW-1:0] ptr_reg;
   integer i;
   // match with global-entry bypass, no added latency
   always @* begin
      hit = 1'b0;
      hitData = 26'h0000000;
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (valid_reg[i] && epn_reg[i] == lookupEpn && ts_reg[i] == lookupTs &&
             (tid_reg[i] == `TSM_GLOBAL_TID || tid_reg[i] == address_space_process_tag)) begin
            hit = 1'b1;
            hitData = data_reg[i];
         end
      end
   end
   // valid bits: flush beats refill, oldest slot overwritten
   always @(posedge clk) begin
      if (!rst_n) begin
         valid_reg <= {N{1'b0}};
         ptr_reg <= {IW{1'b0}};
      end else if (flush) begin
         valid_reg <= {N{1'b0}};
      end else if (fillEn) begin
         valid_reg[ptr_reg] <= 1'b1;
         ptr_reg <= (ptr_reg == N - 1) ? {IW{1'b0}} : ptr_reg + 1'b1;
      end
   end
   // entry contents
   always @(posedge clk) begin
      if (fillEn && !flush) begin
         epn_reg[ptr_reg] <= fillEpn;
         ts_reg[ptr_reg] <= fillTs;
         tid_reg[ptr_reg] <= fillTid;
         data_reg[ptr_reg] <= fillData;
      end
   end
endmodule // tsm_shadow

// Overview of operation
// - process tag register keeps low 8 bits
// - zero owner identifier matches any process tag
// - four instruction, eight data shadow entries
// - shadow hit free; miss stalls four cycles, the miss cycle plus three
// - double miss raises instruction/data miss exception
// - hardware round-robin shadow replacement
// - context sync flushes both shadow arrays
// - entry write leaves shadow entries intact
// - user-mode management ops change nothing
// - search address is base (or zero when base-is-zero is set) plus index
// - search uses search identifier and space
// - search returns matching index in result
// - record search sets condition bit on match
// - search checks only tag parity
// - read/write index is base low six bits
// - word select picks entry word 0-2
// - word 0 identifier uses search identifier field
// - parity readback gated by enable bit
// - read parity error raised regardless of enable
// - write ignores source parity, computes own
// - translation sync is a no-op
// - unified array holds 64 entries
// - eight parity bits per entry
// - refill checks all parity, machine check
module tsm_translation #(
   parameter ENTRIES = `TSM_UNIFIED_ENTRIES
) (
   input wire clk,
   input wire rst_n,
   input wire pidWrEn,
   input wire [31:0] pidWrData,
   output wire [31:0] pidRdData,
   input wire ctrlWrEn,
   input wire [7:0] ctrlWrSearchId,
   input wire ctrlWrSearchSpace,
   output reg [7:0] searchIdentifier,
   output reg searchSpace,
   input wire parityReadbackEnable,
   input wire contextSync,
   input wire fetchReq,
   input wire [31:0] fetchAddr,
   input wire fetchSpace,
   output wire fetchStall,
   output wire [25:0] fetchTranslation,
   input wire dataReq,
   input wire [31:0] dataAddr,
   input wire dataSpace,
   output wire dataStall,
   output wire [25:0] dataTranslation,
   output reg instrMissExc,
   output reg dataMissExc,
   input wire opValid,
   output wire opReady,
   input wire [1:0] opCode,
   input wire opRecord,
   input wire opSupervisor,
   input wire opBaseIsZero,
   input wire [31:0] opBase,
   input wire [31:0] opIndex,
   input wire [1:0] opWordSelect,
   input wire [31:0] opSource,
   output reg opDone,
   output reg opPrivFault,
   output reg [31:0] opResult,
   output reg opCondWrite,
   output reg opCondBit,
   output reg parityErr,
   output reg [1:0] parityErrSrc
);
   reg [`TSM_PID_MSB:0] pid_reg;
   reg [1:0] state_reg;
   reg [1:0] wait_reg;
   reg walkData_reg;
   reg [21:0] walkEpn_reg;
   reg walkTs_reg;
   reg [ENTRIES-1:0] eV_reg;
   reg [21:0] eEpn_reg [0:ENTRIES-1];
   reg eTs_reg [0:ENTRIES-1];
   reg [3:0] eSize_reg [0:ENTRIES-1];
   reg [7:0] eTid_reg [0:ENTRIES-1];
   reg [3:0] eTpar_reg [0:ENTRIES-1];
   reg [25:0] eW1_reg [0:ENTRIES-1];
   reg [1:0] ePar1_reg [0:ENTRIES-1];
   reg [14:0] eW2_reg [0:ENTRIES-1];
   reg [1:0] ePar2_reg [0:ENTRIES-1];
   reg uHit;
   reg [5:0] uIdx;
   reg [21:0] keyEpn;
   reg keyTs;
   reg [7:0] keyTid;
   wire iHit;
   wire dHit;
   wire [31:0] searchEa;
   wire [5:0] rwIdx;
   wire opTake;
   wire walkEnd;
   wire iMiss;
   wire dMiss;
   wire tagBad;
   wire w1Bad;
   wire w2Bad;
   wire [25:0] srcW1;
   wire [14:0] srcW2;
   integer k;

   // tag parity: four bits, ten tag bits each
   function [3:0] tagPar;
      input [39:0] t;
      begin
         tagPar = {^t[39:30], ^t[29:20], ^t[19:10], ^t[9:0]};
      end
   endfunction

   // process tag register, low byte only
   always @(posedge clk) begin
      if (!rst_n)
         pid_reg <= `TSM_PID_RESET;
      else if (pidWrEn)
         pid_reg <= pidWrData[`TSM_PID_MSB:0];
   end
   assign pidRdData = {24'h000000, pid_reg};

   // shadow arrays
   tsm_shadow #(.N(`TSM_INSTR_ENTRIES), .IW(2)) instrShadow (
      .clk(clk), .rst_n(rst_n), .flush(contextSync),
      .lookupEpn(fetchAddr[`TSM_W0_EPN]), .lookupTs(fetchSpace), .address_space_process_tag(pid_reg),
      .fillEn(walkEnd && uHit && !walkData_reg && !tagBad && !w1Bad && !w2Bad),
      .fillEpn(walkEpn_reg), .fillTs(walkTs_reg), .fillTid(eTid_reg[uIdx]),
      .fillData(eW1_reg[uIdx]), .hit(iHit), .hitData(fetchTranslation)
   );
   tsm_shadow #(.N(`TSM_DATA_ENTRIES), .IW(3)) dataShadow (
      .clk(clk), .rst_n(rst_n), .flush(contextSync),
      .lookupEpn(dataAddr[`TSM_W0_EPN]), .lookupTs(dataSpace), .address_space_process_tag(pid_reg),
      .fillEn(walkEnd && uHit && walkData_reg && !tagBad && !w1Bad && !w2Bad),
      .fillEpn(walkEpn_reg), .fillTs(walkTs_reg), .fillTid(eTid_reg[uIdx]),
      .fillData(eW1_reg[uIdx]), .hit(dHit), .hitData(dataTranslation)
   );

   // miss detection and stall
   assign iMiss = fetchReq && !iHit;
   assign dMiss = dataReq && !dHit;
   assign fetchStall = iMiss;
   assign dataStall = dMiss;
   assign walkEnd = state_reg[1] && wait_reg == `TSM_MISS_PENALTY - 1 && !contextSync;
   assign opReady = state_reg[0] && !iMiss && !dMiss;
   assign opTake = opValid && opReady;

   // operand forming
   assign searchEa = (opBaseIsZero ? 32'h00000000 : opBase) + opIndex;
   assign rwIdx = opBase[`TSM_INDEX_MSB:0];

   // unified lookup key: walker uses process tag, search uses control fields
   always @* begin
      if (state_reg[1]) begin
         keyEpn = walkEpn_reg;
         keyTs = walkTs_reg;
         keyTid = pid_reg;
      end else begin
         keyEpn = searchEa[`TSM_W0_EPN];
         keyTs = searchSpace;
         keyTid = searchIdentifier;
      end
   end

   // priority search, lowest index wins
   always @* begin
      uHit = 1'b0;
      uIdx = 6'h00;
      for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
         if (eV_reg[k] && eEpn_reg[k] == keyEpn && eTs_reg[k] == keyTs &&
             (eTid_reg[k] == `TSM_GLOBAL_TID || eTid_reg[k] == keyTid)) begin
            uHit = 1'b1;
            uIdx = k[5:0];
         end
      end
   end

   // parity checks on the selected entry
   assign tagBad = tagPar({eEpn_reg[uIdx], eV_reg[uIdx], eTs_reg[uIdx], eSize_reg[uIdx],
                           eTid_reg[uIdx], 4'h0}) != eTpar_reg[uIdx];
   assign w1Bad = {^eW1_reg[uIdx][25:13], ^eW1_reg[uIdx][12:0]} != ePar1_reg[uIdx];
   assign w2Bad = {^eW2_reg[uIdx][14:8], ^eW2_reg[uIdx][7:0]} != ePar2_reg[uIdx];

   // miss walker: one-hot state, fixed penalty count
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= `TSM_ST_IDLE;
         wait_reg <= 2'h0;
         walkData_reg <= 1'b0;
         walkEpn_reg <= 22'h000000;
         walkTs_reg <= 1'b0;
      end else begin
         case (state_reg)
            `TSM_ST_IDLE: begin
               wait_reg <= 2'h0;
               if ((iMiss || dMiss) && !contextSync) begin
                  state_reg <= `TSM_ST_WALK;
                  walkData_reg <= !iMiss;
                  walkEpn_reg <= iMiss ? fetchAddr[`TSM_W0_EPN] : dataAddr[`TSM_W0_EPN];
                  walkTs_reg <= iMiss ? fetchSpace : dataSpace;
               end
            end
            `TSM_ST_WALK: begin
               wait_reg <= wait_reg + 2'h1;
               if (contextSync || walkEnd)
                  state_reg <= `TSM_ST_IDLE;
            end
            default: state_reg <= `TSM_ST_IDLE;
         endcase
      end
   end

   // miss exceptions and parity pulses
   always @(posedge clk) begin
      if (!rst_n) begin
         instrMissExc <= 1'b0;
         dataMissExc <= 1'b0;
         parityErr <= 1'b0;
         parityErrSrc <= `TSM_PSRC_SEARCH;
      end else begin
         instrMissExc <= walkEnd && !uHit && !walkData_reg;
         dataMissExc <= walkEnd && !uHit && walkData_reg;
         parityErr <= 1'b0;
         if (walkEnd && uHit && (tagBad || w1Bad || w2Bad)) begin
            parityErr <= 1'b1;
            parityErrSrc <= walkData_reg ? `TSM_PSRC_DREFILL : `TSM_PSRC_IREFILL;
         end else if (opTake && opSupervisor && opCode == `TSM_OP_SEARCH && uHit && tagBad) begin
            parityErr <= 1'b1;
            parityErrSrc <= `TSM_PSRC_SEARCH;
         end else if (opTake && opSupervisor && opCode == `TSM_OP_READ && eV_reg[rwIdx] |
                      ~eV_reg[rwIdx]) begin
            case (opWordSelect)
               `TSM_WS_WORD0: parityErr <= tagPar({eEpn_reg[rwIdx], eV_reg[rwIdx], eTs_reg[rwIdx],
                                 eSize_reg[rwIdx], eTid_reg[rwIdx], 4'h0}) != eTpar_reg[rwIdx];
               `TSM_WS_WORD1: parityErr <= {^eW1_reg[rwIdx][25:13], ^eW1_reg[rwIdx][12:0]} !=
                                 ePar1_reg[rwIdx];
               `TSM_WS_WORD2: parityErr <= {^eW2_reg[rwIdx][14:8], ^eW2_reg[rwIdx][7:0]} !=
                                 ePar2_reg[rwIdx];
               default: parityErr <= 1'b0;
            endcase
            parityErrSrc <= `TSM_PSRC_READ;
         end
      end
   end

   // write-side source fields, parity bits of the source dropped
   assign srcW1 = {opSource[`TSM_W1_HI], opSource[`TSM_W1_LO]};
   assign srcW2 = opSource[`TSM_W2_DATA];

   // unified valid bits; shadow arrays are not touched by writes
   always @(posedge clk) begin
      if (!rst_n)
         eV_reg <= {ENTRIES{1'b0}};
      else if (opTake && opSupervisor && opCode == `TSM_OP_WRITE && opWordSelect == `TSM_WS_WORD0)
         eV_reg[rwIdx] <= opSource[`TSM_W0_VALID];
   end

   // unified entry words with hardware parity
   always @(posedge clk) begin
      if (opTake && opSupervisor && opCode == `TSM_OP_WRITE) begin
         case (opWordSelect)
            `TSM_WS_WORD0: begin
               eEpn_reg[rwIdx] <= opSource[`TSM_W0_EPN];
               eTs_reg[rwIdx] <= opSource[`TSM_W0_SPACE];
               eSize_reg[rwIdx] <= opSource[`TSM_W0_SIZE];
               eTid_reg[rwIdx] <= searchIdentifier;
               eTpar_reg[rwIdx] <= tagPar({opSource[`TSM_W0_EPN], opSource[`TSM_W0_VALID],
                  opSource[`TSM_W0_SPACE], opSource[`TSM_W0_SIZE], searchIdentifier, 4'h0});
            end
            `TSM_WS_WORD1: begin
               eW1_reg[rwIdx] <= srcW1;
               ePar1_reg[rwIdx] <= {^srcW1[25:13], ^srcW1[12:0]};
            end
            `TSM_WS_WORD2: begin
               eW2_reg[rwIdx] <= srcW2;
               ePar2_reg[rwIdx] <= {^srcW2[14:8], ^srcW2[7:0]};
            end
            default: ;
         endcase
      end
   end

   // control register fields, word 0 read loads identifier
   always @(posedge clk) begin
      if (!rst_n) begin
         searchIdentifier <= `TSM_GLOBAL_TID;
         searchSpace <= 1'b0;
      end else if (opTake && opSupervisor && opCode == `TSM_OP_READ && opWordSelect == `TSM_WS_WORD0) begin
         searchIdentifier <= eTid_reg[rwIdx];
      end else if (ctrlWrEn) begin
         searchIdentifier <= ctrlWrSearchId;
         searchSpace <= ctrlWrSearchSpace;
      end
   end

   // management results: search, read, sync, privilege
   always @(posedge clk) begin
      if (!rst_n) begin
         opDone <= 1'b0;
         opPrivFault <= 1'b0;
         opResult <= 32'h00000000;
         opCondWrite <= 1'b0;
         opCondBit <= 1'b0;
      end else begin
         opDone <= opTake;
         opPrivFault <= opTake && !opSupervisor;
         opCondWrite <= opTake && opSupervisor && opCode == `TSM_OP_SEARCH && opRecord;
         if (opTake && opSupervisor) begin
            case (opCode)
               `TSM_OP_SEARCH: begin
                  opResult <= {26'h0000000, uIdx};
                  opCondBit <= uHit;
               end
               `TSM_OP_READ: begin
                  case (opWordSelect)
                     `TSM_WS_WORD0: opResult <= {eEpn_reg[rwIdx], eV_reg[rwIdx], eTs_reg[rwIdx],
                        eSize_reg[rwIdx], parityReadbackEnable ? eTpar_reg[rwIdx] : 4'h0};
                     `TSM_WS_WORD1: opResult <= {eW1_reg[rwIdx][25:4],
                        parityReadbackEnable ? ePar1_reg[rwIdx] : 2'h0, 4'h0, eW1_reg[rwIdx][3:0]};
                     `TSM_WS_WORD2: opResult <= {parityReadbackEnable ? ePar2_reg[rwIdx] : 2'h0,
                        15'h0000, eW2_reg[rwIdx]};
                     default: opResult <= 32'h00000000;
                  endcase
               end
               default: ;
            endcase
         end
      end
   end
endmodule // tsm_translation
`default_nettype wire

// ---- hdl/tsm_translation_map.vh ----
// constants for the translation shadow and management block
`ifndef TSM_TRANSLATION_MAP_VH
`define TSM_TRANSLATION_MAP_VH
`define TSM_UNIFIED_ENTRIES 64
`define TSM_INSTR_ENTRIES 4
`define TSM_DATA_ENTRIES 8
`define TSM_MISS_PENALTY 3
`define TSM_PID_MSB 7
`define TSM_PID_RESET 8'h00
`define TSM_GLOBAL_TID 8'h00
`define TSM_INDEX_MSB 5
// management operation codes
`define TSM_OP_SEARCH 2'h0
`define TSM_OP_READ 2'h1
`define TSM_OP_WRITE 2'h2
`define TSM_OP_SYNC 2'h3
// word select codes
`define TSM_WS_WORD0 2'h0
`define TSM_WS_WORD1 2'h1
`define TSM_WS_WORD2 2'h2
// parity error sources
`define TSM_PSRC_SEARCH 2'h0
`define TSM_PSRC_READ 2'h1
`define TSM_PSRC_IREFILL 2'h2
`define TSM_PSRC_DREFILL 2'h3
// one-hot walker states
`define TSM_ST_IDLE 2'h1
`define TSM_ST_WALK 2'h2
// word 0 layout in the general register
`define TSM_W0_EPN 31:10
`define TSM_W0_VALID 9
`define TSM_W0_SPACE 8
`define TSM_W0_SIZE 7:4
`define TSM_W0_TAG_PARITY_FIELD 3:0
// word 1 layout: data high part, parity, data low part
`define TSM_W1_HI 31:10
`define TSM_W1_PAR 9:8
`define TSM_W1_LO 3:0
// word 2 layout
`define TSM_W2_PAR 31:30
`define TSM_W2_DATA 14:0
`endif

// ---- dv/tsm_translation_props.sv ----
// checker of the translation shadow and management ports
`timescale 1ns/1ns
`default_nettype none
`include "tsm_translation_map.vh"
module tsm_translation_props #(
   parameter ENTRIES = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pidWrEn,
   input wire logic [31:0] pidWrData,
   input wire logic [31:0] pidRdData,
   input wire logic ctrlWrEn,
   input wire logic [7:0] ctrlWrSearchId,
   input wire logic [7:0] searchIdentifier,
   input wire logic contextSync,
   input wire logic fetchStall,
   input wire logic dataStall,
   input wire logic instrMissExc,
   input wire logic dataMissExc,
   input wire logic opValid,
   input wire logic opReady,
   input wire logic [1:0] opCode,
   input wire logic opRecord,
   input wire logic opSupervisor,
   input wire logic [1:0] opWordSelect,
   input wire logic opDone,
   input wire logic opPrivFault,
   input wire logic [31:0] opResult,
   input wire logic opCondWrite,
   input wire logic opCondBit
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // accepted op, and a privileged word 0 read that owns the identifier
   wire logic taken;
   wire logic rdWord0;
   assign taken = opValid && opReady;
   assign rdWord0 = taken && opSupervisor && opCode == `TSM_OP_READ && opWordSelect == `TSM_WS_WORD0;
   // a miss stalls for the miss cycle plus the penalty, then hits or faults
   sequence fetch_walk;
      fetchStall [*4] ##1 (!fetchStall || instrMissExc);
   endsequence
   sequence data_walk;
      dataStall [*4] ##1 (!dataStall || dataMissExc);
   endsequence
   a_pid_low: assert property (pidWrEn |=> pidRdData[7:0] == $past(pidWrData[7:0]))
      else $error("tag write not kept");
   a_pid_upper: assert property (pidRdData[31:8] == 24'h000000)
      else $error("tag upper bits not zero");
   a_op_done: assert property (taken |=> opDone)
      else $error("op not finished in one cycle");
   a_user_block: assert property (taken && !opSupervisor |=> opPrivFault && $stable(opResult) && !opCondWrite)
      else $error("user op changed state");
   a_cond_record: assert property (taken && opSupervisor && opCode == `TSM_OP_SEARCH |=> opCondWrite == $past(opRecord))
      else $error("condition write wrong");
   a_sync_quiet: assert property (taken && opSupervisor && opCode == `TSM_OP_SYNC |=> !opCondWrite && $stable(opResult))
      else $error("sync did something");
   a_ctrl_write: assert property (ctrlWrEn && !rdWord0 |=> searchIdentifier == $past(ctrlWrSearchId))
      else $error("search identifier write lost");
   a_fetch_walk: assert property (disable iff (!rst_n || contextSync) $rose(fetchStall) |-> fetch_walk)
      else $error("fetch miss timing wrong");
   a_data_walk: assert property (disable iff (!rst_n || contextSync) $rose(dataStall) && !fetchStall |-> data_walk)
      else $error("data miss timing wrong");
   a_stall_ready: assert property ((fetchStall || dataStall) |-> !opReady)
      else $error("op ready during miss");
   a_index_range: assert property (opCondWrite && opCondBit |-> opResult < ENTRIES)
      else $error("search index out of range");
endmodule // tsm_translation_props
`default_nettype wire

// ---- dv/tsm_pipe_model.sv ----
// pipeline-side model issuing fetch and data translation requests
`timescale 1ns/1ns
`default_nettype none
module tsm_pipe_model (
   input wire logic clk,
   output logic fetchReq,
   output logic [31:0] fetchAddr,
   output logic fetchSpace,
   input wire logic fetchStall,
   input wire logic [25:0] fetchTranslation,
   input wire logic instrMissExc,
   output logic dataReq,
   output logic [31:0] dataAddr,
   output logic dataSpace,
   input wire logic dataStall,
   input wire logic [25:0] dataTranslation,
   input wire logic dataMissExc
);
   // idle at time zero
   initial begin
      {fetchReq, fetchSpace, dataReq, dataSpace} = 4'h0;
      {fetchAddr, dataAddr} = 64'h0;
   end
   // one access held while stalled, stall cycles counted at falling edges
   task automatic access(input logic isData, input logic [31:0] a, output int cnt, output logic exc,
                         output logic [25:0] xl);
      cnt = 0;
      exc = 1'b0;
      xl = 26'h0;
      @(negedge clk);
      if (isData) begin
         dataReq = 1'b1;
         dataAddr = a;
      end else begin
         fetchReq = 1'b1;
         fetchAddr = a;
      end
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         if (isData ? dataMissExc : instrMissExc) begin
            exc = 1'b1;
            break;
         end
         if (!(isData ? dataStall : fetchStall)) begin
            xl = isData ? dataTranslation : fetchTranslation;
            break;
         end
         cnt++;
      end
      // released address lines show the inverse of the last value
      {fetchReq, dataReq} = 2'h0;
      fetchAddr = ~fetchAddr;
      dataAddr = ~dataAddr;
   endtask
endmodule // tsm_pipe_model
`default_nettype wire

// ---- dv/tsm_translation_tb_top.sv ----
// self-checking bench of the translation shadow and management block
`timescale 1ns/1ns
`default_nettype none
`include "tsm_translation_map.vh"
module tsm_translation_tb_top;
   typedef struct packed {
      logic [8:0] key; logic [1:0] code; logic rec; logic sup; logic bz; logic [31:0] base; logic [31:0] idx;
      logic [1:0] ws; logic pe; logic [31:0] src; logic [31:0] res; logic [2:0] flg;
   } tsm_row_t;
   localparam int MISS = `TSM_MISS_PENALTY; // stall cycles seen after the miss cycle
   logic clk = 1'b0, rst_n = 1'b0, pidWrEn = 1'b0, ctrlWrEn = 1'b0, ctrlWrSearchSpace = 1'b0;
   logic parityReadbackEnable = 1'b0, contextSync = 1'b0, opValid = 1'b0, opRecord = 1'b0;
   logic opSupervisor = 1'b0, opBaseIsZero = 1'b0, exc;
   logic [31:0] pidWrData = 32'h0, opBase = 32'h0, opIndex = 32'h0, opSource = 32'h0;
   logic [7:0] ctrlWrSearchId = 8'h0;
   logic [1:0] opCode = 2'h0, opWordSelect = 2'h0;
   logic [25:0] xl;
   wire logic [31:0] pidRdData, fetchAddr, dataAddr, opResult;
   wire logic [25:0] fetchTranslation, dataTranslation;
   wire logic [7:0] searchIdentifier;
   wire logic [1:0] parityErrSrc;
   wire logic searchSpace, fetchReq, fetchSpace, fetchStall, dataReq, dataSpace, dataStall, instrMissExc;
   wire logic dataMissExc, opReady, opDone, opPrivFault, opCondWrite, opCondBit, parityErr;
   int err_total = 0, tests_run = 0, cnt;
   // ordinary ops: {space,id}, code, record, supervisor, base zero, base, index, word, readback, source, result, flags
   tsm_row_t rows [15] = '{
      '{9'h033, 2'h0, 1'b1, 1'b1, 1'b0, 32'hFC000000, 32'h0, 2'h0, 1'b0, 32'h0, 32'h9, 3'h3},
      '{9'h055, 2'h0, 1'b1, 1'b1, 1'b0, 32'hFB000000, 32'h01000000, 2'h0, 1'b0, 32'h0, 32'hC, 3'h3},
      '{9'h055, 2'h0, 1'b1, 1'b1, 1'b1, 32'h12345678, 32'h048D1400, 2'h0, 1'b0, 32'h0, 32'h5, 3'h3},
      '{9'h055, 2'h0, 1'b1, 1'b1, 1'b0, 32'h0, 32'h00001000, 2'h0, 1'b0, 32'h0, 32'h0, 3'h2},
      '{9'h055, 2'h0, 1'b0, 1'b1, 1'b0, 32'h0, 32'h048D1400, 2'h0, 1'b0, 32'h0, 32'h5, 3'h0},
      '{9'h155, 2'h0, 1'b1, 1'b1, 1'b0, 32'h0, 32'h048D1400, 2'h0, 1'b0, 32'h0, 32'h0, 3'h2},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h45, 32'h0, 2'h1, 1'b0, 32'h0, 32'hFFFFFC0F, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h1, 1'b1, 32'h0, 32'hFFFFFF0F, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h2, 1'b0, 32'h0, 32'h00007FFF, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h2, 1'b1, 32'h0, 32'h80007FFF, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h0, 1'b0, 32'h0, 32'h048D1610, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b0, 1'b0, 32'h5, 32'h0, 2'h2, 1'b0, 32'h0, 32'h048D1610, 3'h4},
      '{9'h000, 2'h2, 1'b0, 1'b0, 1'b0, 32'h5, 32'h0, 2'h1, 1'b0, 32'h0, 32'h048D1610, 3'h4},
      '{9'h000, 2'h3, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h0, 1'b0, 32'h0, 32'h048D1610, 3'h0},
      '{9'h000, 2'h1, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, 2'h1, 1'b0, 32'h0, 32'hFFFFFC0F, 3'h0}};
   tsm_translation #(.ENTRIES(64)) u_tsm_translation (.*);
   tsm_pipe_model u_tsm_pipe_model (.*);
   always #5 clk = ~clk;
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic close_out;
      $display("mismatches=%0d comparisons=%0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one-cycle write of the process tag or the search fields
   task automatic reg_wr(input logic ctrl, input logic [31:0] d);
      @(negedge clk);
      if (ctrl) {ctrlWrEn, ctrlWrSearchSpace, ctrlWrSearchId} = {1'b1, d[8:0]};
      else {pidWrEn, pidWrData} = {1'b1, d};
      @(negedge clk);
      {ctrlWrEn, pidWrEn} = 2'h0;
   endtask
   // management op held until taken, done expected one cycle later
   task automatic op(input tsm_row_t r);
      @(negedge clk);
      {opCode, opRecord, opSupervisor, opBaseIsZero, opBase, opIndex, opWordSelect} =
         {r.code, r.rec, r.sup, r.bz, r.base, r.idx, r.ws};
      {parityReadbackEnable, opSource, opValid} = {r.pe, r.src, 1'b1};
      for (int i = 0; i < 50 && opReady !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      opValid = 1'b0;
      check(opDone, 1'b1);
   endtask
   // entry write: data words first, word 0 validates it last
   task automatic put(input logic [5:0] e, input logic [7:0] entry_owner_identifier, input logic [31:0] w0, w1, w2);
      reg_wr(1'b1, {24'h0, entry_owner_identifier});
      for (int w = 1; w < 4; w++)
         op('{9'h0, `TSM_OP_WRITE, 1'b0, 1'b1, 1'b0, {26'h0, e}, 32'h0, 2'(w % 3), 1'b0,
              (w == 1) ? w1 : (w == 2) ? w2 : w0, 32'h0, 3'h0});
   endtask
   task automatic acc(input logic d, input logic [31:0] a, input logic e, input logic [25:0] x, input int n);
      u_tsm_pipe_model.access(d, a, cnt, exc, xl);
      check({exc, xl}, {e, x});
      check(cnt, n);
   endtask
   task automatic sync_ctx;
      @(negedge clk);
      contextSync = 1'b1;
      @(negedge clk);
      contextSync = 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      check(pidRdData, 32'h0);
      check(searchIdentifier, 8'h0);
      check(opResult, 32'h0);
      reg_wr(1'b0, 32'h1AB);
      check(pidRdData, 32'h000000AB);
      reg_wr(1'b0, 32'h0);
      acc(1'b0, 32'h048D1400, 1'b1, 26'h0, MISS);
      acc(1'b1, 32'h048D1400, 1'b1, 26'h0, MISS);
      put(6'd5, 8'h00, 32'h048D1610, 32'hFFFFFC0F, 32'h40007FFF);
      put(6'd9, 8'h33, 32'hFC000210, 32'h12345C03, 32'h0);
      put(6'd12, 8'h00, 32'hFC000210, 32'h00000005, 32'h0);
      for (int i = 0; i < 5; i++) put(6'(20 + i), 8'h00, 32'h00040210 + (i << 10), i << 10, 32'h0);
      foreach (rows[k]) begin
         reg_wr(1'b1, {23'h0, rows[k].key});
         op(rows[k]);
         check(opResult, rows[k].res);
         check({opPrivFault, opCondWrite, opCondWrite & opCondBit}, rows[k].flg);
         check(parityErr, 1'b0);
      end
      // word 0 read hands the owner identifier to the search field
      reg_wr(1'b1, 32'h55);
      op('{9'h0, `TSM_OP_READ, 1'b0, 1'b1, 1'b0, 32'h9, 32'h0, `TSM_WS_WORD0, 1'b0, 32'h0, 32'h0, 3'h0});
      check(opResult, 32'hFC000210);
      check(searchIdentifier, 8'h33);
      // refill, free hit, and a write that leaves the shadow copy alone
      acc(1'b0, 32'h048D1403, 1'b0, 26'h3FFFFFF, MISS);
      acc(1'b0, 32'h048D17FF, 1'b0, 26'h3FFFFFF, 0);
      op('{9'h0, `TSM_OP_WRITE, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0, `TSM_WS_WORD1, 1'b0, 32'h00000C00, 32'h0, 3'h0});
      acc(1'b0, 32'h048D1400, 1'b0, 26'h3FFFFFF, 0);
      sync_ctx;
      acc(1'b0, 32'h048D1400, 1'b0, 26'h30, MISS);
      acc(1'b1, 32'hFC000010, 1'b0, 26'h5, MISS);
      // tag change is followed by a context sync before use
      reg_wr(1'b0, 32'h33);
      sync_ctx;
      acc(1'b1, 32'hFC000010, 1'b0, 26'h048D173, MISS);
      // five pages through four instruction slots and eight data slots
      for (int i = 0; i < 5; i++) acc(1'b0, 32'h00040000 + (i << 10), 1'b0, 26'(i << 4), MISS);
      acc(1'b0, 32'h00040400, 1'b0, 26'h10, 0);
      acc(1'b0, 32'h00040000, 1'b0, 26'h0, MISS);
      for (int i = 0; i < 5; i++) acc(1'b1, 32'h00040000 + (i << 10), 1'b0, 26'(i << 4), MISS);
      acc(1'b1, 32'h00040000, 1'b0, 26'h0, 0);
      // mid-run reset empties tag, search fields and both arrays
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      check(pidRdData, 32'h0);
      check(searchIdentifier, 8'h0);
      acc(1'b1, 32'h00040000, 1'b1, 26'h0, MISS);
      close_out;
   end
   // watchdog against a hang
   initial begin
      #500000;
      err_total++;
      close_out;
   end
endmodule // tsm_translation_tb_top
bind tsm_translation tsm_translation_props #(.ENTRIES(ENTRIES)) u_tsm_translation_props (.*);
`default_nettype wire
